// [hdl/pcm_pkg.sv]
`default_nettype none
package pcm_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int           PCM_NUM_PADS   = 12;
   localparam int           PCM_NUM_CODES  = 8;
   localparam logic [7:0]   PCM_OFF_PADS_0_3  = 8'h00;
   localparam logic [7:0]   PCM_OFF_PADS_4_7  = 8'h04;
   localparam logic [7:0]   PCM_OFF_PADS_8_11 = 8'h08;
   localparam logic [7:0]   PCM_OFF_KEY       = 8'h60;

   // register indices returned by the address decoder
   localparam logic [2:0]   PCM_IDX_PADS_0_3  = 3'h0;
   localparam logic [2:0]   PCM_IDX_PADS_4_7  = 3'h1;
   localparam logic [2:0]   PCM_IDX_PADS_8_11 = 3'h2;
   localparam logic [2:0]   PCM_IDX_KEY       = 3'h3;
   localparam logic [2:0]   PCM_IDX_NONE      = 3'h4;

   // every selector resets to the general-purpose code, other fields to zero
   localparam logic [31:0]  PCM_RST_PADS   = 32'h18181818;
   localparam logic [2:0]   PCM_FSEL_GPIO  = 3'h3;

   // writable bits; reserved bits are held at zero
   localparam logic [31:0]  PCM_MASK_PADS_0_3  = 32'hBF3F3F3F;
   localparam logic [31:0]  PCM_MASK_PADS_4_7  = 32'h3FFFFFBF;
   localparam logic [31:0]  PCM_MASK_PADS_8_11 = 32'h5F3FFFFF;

   // field positions inside each pad's byte lane
   localparam int           PCM_FLD_PULL   = 0;
   localparam int           PCM_FLD_INPEN  = 1;
   localparam int           PCM_FLD_DRIVE  = 2;
   localparam int           PCM_FLD_FSEL   = 3;
   localparam int           PCM_FLD_LOWPWR = 6;
   localparam int           PCM_FLD_RSEL   = 6;
   localparam int           PCM_FLD_UPPWR  = 7;

   // which pads own the optional fields in bits 7:6 of their lane
   localparam logic [11:0]  PCM_HAS_RSEL   = 12'h360;
   localparam logic [11:0]  PCM_HAS_UPPWR  = 12'h018;
   localparam logic [11:0]  PCM_HAS_LOWPWR = 12'h800;

   // listed driving codes per pad, pad 11 in the top byte
   localparam logic [95:0]  PCM_FUNC_LEGAL =
      {8'h0F, 8'h8F, 8'hAF, 8'hAF, 8'h4F, 8'h5F, 8'h5F, 8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF};

   // axi response codes
   localparam logic [1:0]   PCM_RESP_OKAY   = 2'h0;
   localparam logic [1:0]   PCM_RESP_SLVERR = 2'h2;

   // electrical and routing view of one pad
   typedef struct packed {
      logic [2:0] fsel;
      logic       drive_high;
      logic       input_en;
      logic       pullup_en;
      logic [1:0] pullup_res;
      logic       upper_pwr;
      logic       lower_pwr;
   } pcm_pad_cfg_t;

   // true when a code routes a real function onto the pad
   function automatic logic pcm_func_legal(input int pad, input logic [2:0] code);
      pcm_func_legal = PCM_FUNC_LEGAL[pad * PCM_NUM_CODES + int'(code)];
   endfunction

   // word address to register index
   function automatic logic [2:0] pcm_reg_sel(input logic [7:0] addr);
      unique case (addr)
         PCM_OFF_PADS_0_3:  pcm_reg_sel = PCM_IDX_PADS_0_3;
         PCM_OFF_PADS_4_7:  pcm_reg_sel = PCM_IDX_PADS_4_7;
         PCM_OFF_PADS_8_11: pcm_reg_sel = PCM_IDX_PADS_8_11;
         PCM_OFF_KEY:       pcm_reg_sel = PCM_IDX_KEY;
         default:           pcm_reg_sel = PCM_IDX_NONE;
      endcase
   endfunction

   // byte-strobed merge of a write, reserved bits forced low
   function automatic logic [31:0] pcm_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      pcm_merge = ((old & ~lanes) | (wdata & lanes)) & mask;
   endfunction

endpackage
`default_nettype wire

// [hdl/pcm_pad_mux.sv]
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module pcm_pad_mux
   import pcm_pkg::*;
#(
   parameter logic [31:0] KEY_VALUE = 32'h0000_00A5  // arbitrary unlock word
)(
   // clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // axi4-lite write address
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // peripheral side, indexed [pad][function code]
   input  wire logic [11:0][7:0]      periph_out,
   input  wire logic [11:0][7:0]      periph_oe,
   output logic      [11:0][7:0]      periph_in,
   // pad cells
   input  wire logic [11:0]           pad_in,
   output logic      [11:0]           pad_out,
   output logic      [11:0]           pad_oe,
   output pcm_pad_cfg_t [11:0]        pad_cfg,
   // lock state
   output logic                       pads_unlocked
);

   // ***************************************************************
   // state
   // ***************************************************************
   logic [31:0]        pads_0_3_reg;
   logic [31:0]        pads_4_7_reg;
   logic [31:0]        pads_8_11_reg;
   logic               unlock_reg;
   logic               aw_held_reg;
   logic [7:0]         aw_addr_reg;
   logic               w_held_reg;
   logic [31:0]        w_data_reg;
   logic [3:0]         w_strb_reg;
   logic               bvalid_reg;
   logic [1:0]         bresp_reg;
   logic               rvalid_reg;
   logic [31:0]        rdata_reg;
   logic [1:0]         rresp_reg;
   logic [11:0]        pad_in_meta_reg;
   logic [11:0]        pad_in_sync_reg;
   logic [11:0]        pad_out_reg;
   logic [11:0]        pad_oe_reg;
   logic [11:0][7:0]   periph_in_reg;
   logic [95:0]        pad_bytes;
   logic               wr_fire;
   logic [2:0]         wr_idx;
   logic [2:0]         rd_idx;
   logic [11:0]        route_ok;

   // ***************************************************************
   // axi write channel
   // ***************************************************************

   // address and data may arrive in either order; each is held until both are in;
   // handshakes are masked by ce so a frozen block neither takes nor answers a beat
   assign s_axi_awready = ce & ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready  = ce & ~w_held_reg & ~bvalid_reg;
   assign s_axi_bvalid  = ce & bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign wr_fire       = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_idx        = pcm_reg_sel(aw_addr_reg);

   // capture write address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
      end
   end

   // capture write data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // write response valid; raised once both halves are in, dropped when taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid_reg <= 1'b0;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // write response code; a locked pad write is refused with slverr so software sees it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bresp_reg <= PCM_RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            if (wr_idx == PCM_IDX_NONE) begin
               bresp_reg <= PCM_RESP_SLVERR;
            end else if (wr_idx != PCM_IDX_KEY && !unlock_reg) begin
               bresp_reg <= PCM_RESP_SLVERR;
            end else begin
               bresp_reg <= PCM_RESP_OKAY;
            end
         end
      end
   end

   // ***************************************************************
   // key and pad registers
   // ***************************************************************

   // one key for all three words; any other value locks again
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unlock_reg <= 1'b0;
      end else if (ce) begin
         if (wr_fire && wr_idx == PCM_IDX_KEY) begin
            unlock_reg <= (w_strb_reg == 4'hF) && (w_data_reg == KEY_VALUE);
         end
      end
   end

   // pads 0 to 3; merge masks drop reserved bits so they always read zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pads_0_3_reg <= PCM_RST_PADS;
      end else if (ce) begin
         if (wr_fire && unlock_reg && wr_idx == PCM_IDX_PADS_0_3) begin
            pads_0_3_reg <= pcm_merge(pads_0_3_reg, w_data_reg, w_strb_reg,
                                      PCM_MASK_PADS_0_3);
         end
      end
   end

   // pads 4 to 7; resistor choices of pads 5 and 6 and the upper switch of pad 4 live here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pads_4_7_reg <= PCM_RST_PADS;
      end else if (ce) begin
         if (wr_fire && unlock_reg && wr_idx == PCM_IDX_PADS_4_7) begin
            pads_4_7_reg <= pcm_merge(pads_4_7_reg, w_data_reg, w_strb_reg,
                                      PCM_MASK_PADS_4_7);
         end
      end
   end

   // pads 8 to 11; pad 11 has a two-bit selector, its top code bit is reserved
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pads_8_11_reg <= PCM_RST_PADS;
      end else if (ce) begin
         if (wr_fire && unlock_reg && wr_idx == PCM_IDX_PADS_8_11) begin
            pads_8_11_reg <= pcm_merge(pads_8_11_reg, w_data_reg, w_strb_reg,
                                       PCM_MASK_PADS_8_11);
         end
      end
   end

   assign pads_unlocked = unlock_reg;

   // ***************************************************************
   // axi read channel
   // ***************************************************************

   // one read outstanding; the next address waits until the data is taken
   assign s_axi_arready = ce & ~rvalid_reg;
   assign s_axi_rvalid  = ce & rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign rd_idx        = pcm_reg_sel(s_axi_araddr);

   // read valid rises the cycle after the address is taken and stands until rready
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // read data; the key word shows the lock state, never the key itself
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= PCM_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rresp_reg <= PCM_RESP_OKAY;
            unique case (rd_idx)
               PCM_IDX_PADS_0_3:  rdata_reg <= pads_0_3_reg;
               PCM_IDX_PADS_4_7:  rdata_reg <= pads_4_7_reg;
               PCM_IDX_PADS_8_11: rdata_reg <= pads_8_11_reg;
               PCM_IDX_KEY:       rdata_reg <= {31'h0000_0000, unlock_reg};
               default: begin
                  rdata_reg <= 32'h0000_0000;
                  rresp_reg <= PCM_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ***************************************************************
   // field decode
   // ***************************************************************

   // every pad owns one byte lane with the same layout
   assign pad_bytes = {pads_8_11_reg, pads_4_7_reg, pads_0_3_reg};

   // unpack lanes; optional bits only exist where the pad has them
   always_comb begin
      for (int i = 0; i < PCM_NUM_PADS; i++) begin
         pad_cfg[i].fsel       = pad_bytes[i*8 + PCM_FLD_FSEL +: 3];
         pad_cfg[i].drive_high = pad_bytes[i*8 + PCM_FLD_DRIVE];
         pad_cfg[i].input_en   = pad_bytes[i*8 + PCM_FLD_INPEN];
         pad_cfg[i].pullup_en  = pad_bytes[i*8 + PCM_FLD_PULL];
         pad_cfg[i].pullup_res = PCM_HAS_RSEL[i] ?
                                 pad_bytes[i*8 + PCM_FLD_RSEL +: 2] : 2'h0;
         pad_cfg[i].upper_pwr  = PCM_HAS_UPPWR[i] &
                                 pad_bytes[i*8 + PCM_FLD_UPPWR];
         pad_cfg[i].lower_pwr  = PCM_HAS_LOWPWR[i] &
                                 pad_bytes[i*8 + PCM_FLD_LOWPWR];
      end
   end

   // ***************************************************************
   // pad input synchroniser
   // ***************************************************************

   // pins are asynchronous to clk; this first stage may go metastable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_in_meta_reg <= 12'h000;
      end else if (ce) begin
         pad_in_meta_reg <= pad_in;
      end
   end

   // second stage is the only reader of the first and the only copy the mux uses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_in_sync_reg <= 12'h000;
      end else if (ce) begin
         pad_in_sync_reg <= pad_in_meta_reg;
      end
   end

   // ***************************************************************
   // function routing
   // ***************************************************************

   // legality of the code each pad holds now; disabled and unlisted codes fail it
   always_comb begin
      for (int i = 0; i < PCM_NUM_PADS; i++) begin
         route_ok[i] = pcm_func_legal(i, pad_cfg[i].fsel);
      end
   end

   // registered mux costs one cycle of latency but keeps pad outputs glitch free
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_out_reg <= 12'h000;
      end else if (ce) begin
         for (int i = 0; i < PCM_NUM_PADS; i++) begin
            if (route_ok[i]) begin
               pad_out_reg[i] <= periph_out[i][pad_cfg[i].fsel];
            end else begin
               pad_out_reg[i] <= 1'b0;
            end
         end
      end
   end

   // output enable follows the routed function; off for disabled or unlisted codes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_oe_reg <= 12'h000;
      end else if (ce) begin
         for (int i = 0; i < PCM_NUM_PADS; i++) begin
            if (route_ok[i]) begin
               pad_oe_reg[i] <= periph_oe[i][pad_cfg[i].fsel];
            end else begin
               pad_oe_reg[i] <= 1'b0;
            end
         end
      end
   end

   // a pin reaches only the function its pad selects, and only with input enabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         periph_in_reg <= '0;
      end else if (ce) begin
         for (int i = 0; i < PCM_NUM_PADS; i++) begin
            for (int c = 0; c < PCM_NUM_CODES; c++) begin
               periph_in_reg[i][c] <= route_ok[i] &&
                                      (pad_cfg[i].fsel == 3'(c)) &&
                                      pad_cfg[i].input_en &&
                                      pad_in_sync_reg[i];
            end
         end
      end
   end

   assign pad_out   = pad_out_reg;
   assign pad_oe    = pad_oe_reg;
   assign periph_in = periph_in_reg;

endmodule
`default_nettype wire

// [sim/pcm_pad_mux_assertions.sv]
`default_nettype none
// ***************************************************************
// pad mux checker
// ***************************************************************
module pcm_pad_mux_assertions
   import pcm_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // write response
   input  wire logic [1:0]          s_axi_bresp,
   input  wire logic                s_axi_bvalid,
   // pad side
   input  wire logic [11:0][7:0]    periph_out,
   input  wire logic [11:0][7:0]    periph_oe,
   input  wire logic [11:0][7:0]    periph_in,
   input  wire logic [11:0]         pad_in,
   input  wire logic [11:0]         pad_out,
   input  wire logic [11:0]         pad_oe,
   input  wire pcm_pad_cfg_t [11:0] pad_cfg,
   input  wire logic                pads_unlocked
);
   // one domain, so clock and reset are given once
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);

   rst_state_a: assert property (
      $fell(rst) |-> !pads_unlocked && pad_cfg[0].fsel == 3'h3 && pad_cfg[11].fsel == 3'h3)
      else $error("pad state wrong after reset");
   locked_hold_a: assert property (
      s_axi_bvalid && s_axi_bresp == PCM_RESP_SLVERR |-> $stable(pad_cfg))
      else $error("refused write changed a pad");
   pad3_off_a: assert property (
      pad_cfg[3].fsel == 3'h6 && $past(pad_cfg[3].fsel) == 3'h6 |-> !pad_oe[3])
      else $error("disabled pad 3 still driven");
   pad7_off_a: assert property (
      pad_cfg[7].fsel == 3'h7 && $past(pad_cfg[7].fsel) == 3'h7 |-> !pad_oe[7])
      else $error("disabled pad 7 still driven");
   pad4_off_a: assert property (
      pad_cfg[4].fsel == 3'h7 && $past(pad_cfg[4].fsel) == 3'h7 |-> !pad_oe[4])
      else $error("disabled pad 4 still driven");
   unlisted_off_a: assert property (
      pad_cfg[7].fsel == 3'h4 && $past(pad_cfg[7].fsel) == 3'h4 |-> !pad_oe[7])
      else $error("unlisted code drives pad 7");
   pad0_out_a: assert property (
      $past(pad_cfg[0].fsel) == 3'h3 && !$past(rst)
      |-> pad_oe[0] == $past(periph_oe[0][3]) && pad_out[0] == $past(periph_out[0][3]))
      else $error("pad 0 output not routed from its gpio");
   pad0_in_a: assert property (
      (pad_cfg[0].fsel == 3'h3 && pad_cfg[0].input_en) [*4] |-> periph_in[0][3] == $past(pad_in[0], 3))
      else $error("pad 0 input not delivered");
   pad1_block_a: assert property (
      (!pad_cfg[1].input_en) [*4] |-> periph_in[1] == 8'h00)
      else $error("pad 1 input passed while disabled");
endmodule

bind pcm_pad_mux pcm_pad_mux_assertions chk (.clk, .rst, .s_axi_bresp, .s_axi_bvalid,
   .periph_out, .periph_oe, .periph_in, .pad_in, .pad_out, .pad_oe, .pad_cfg, .pads_unlocked);
`default_nettype wire

// [sim/pcm_pad_mux_tb_top.sv]
`default_nettype none
module pcm_pad_mux_tb_top
   import pcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // signals
   // ***************************************************************
   localparam logic [31:0] unlock_key = 32'h000000A5;  // arbitrary unlock word
   // drivable codes per pad 0..7, bit c set when code c routes a function
   localparam logic [7:0]  legal_codes [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F,
                                               8'h7F, 8'h5F, 8'h5F, 8'h4F};
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [7:0]          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]         s_axi_wdata = 32'h0;
   logic [3:0]          s_axi_wstrb = 4'h0;
   logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic [31:0]         s_axi_rdata, seed_val, wd;
   logic [11:0][7:0]    periph_out = '0, periph_oe = '0, periph_in;
   logic [11:0]         pad_in = 12'h000, pad_out, pad_oe;
   pcm_pad_cfg_t [11:0] pad_cfg;
   logic                pads_unlocked;
   logic [1:0]          bq [$];
   logic [33:0]         rq [$];
   int                  errors = 0, total_checks = 0;

   pcm_pad_mux #(.KEY_VALUE(unlock_key)) uut (.clk, .rst, .ce(1'b1),
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .periph_out, .periph_oe, .periph_in, .pad_in, .pad_out, .pad_oe, .pad_cfg, .pads_unlocked);

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one clock of a bounded wait; a hang ends the run
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 50) begin
         errors++;
         $display("ERROR t=%0t bus wait timed out", $time);
         report_and_stop();
      end
   endtask

   // address and data offered together, each released once taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] resp);
      int   n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bq.push_back(resp);
      while (!(aw_ok && w_ok)) begin
         tick(n);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) tick(n);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [33:0] exp);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rq.push_back(exp);
      tick(n);
      while (!s_axi_arready) tick(n);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) tick(n);
      s_axi_rready <= 1'b0;
   endtask

   // select code c on pad p, then drive the peripheral and pin sides at random
   task automatic pad_route(input int p, input logic [2:0] c);
      logic [7:0] oe, dat;
      logic       pin, ok;
      oe = 8'($urandom());
      dat = 8'($urandom());
      pin = 1'($urandom());
      ok = legal_codes[p][c];
      axi_write(8'(p / 4 * 4), {4{2'b00, c, 3'b010}}, 4'h1 << (p % 4), PCM_RESP_OKAY);
      periph_oe[p] <= oe;
      periph_out[p] <= dat;
      pad_in[p] <= pin;
      repeat (5) @(posedge clk);
      check(pad_oe[p], ok ? oe[c] : 1'b0);
      if (ok) check(pad_out[p], dat[c]);
      check(periph_in[p], (ok && pin) ? 8'h01 << c : 8'h00);
   endtask

   // scoreboard: each bus answer is matched against the oldest note
   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.pop_front());
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rdata, s_axi_rresp}, rq.pop_front());
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      seed_val = $urandom(32'h77136a5b);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) axi_read(8'(i * 4), {PCM_RST_PADS, PCM_RESP_OKAY});
      axi_read(PCM_OFF_KEY, {32'h0, PCM_RESP_OKAY});
      axi_write(8'h00, 32'h0, 4'hF, PCM_RESP_SLVERR);
      axi_read(8'h00, {PCM_RST_PADS, PCM_RESP_OKAY});
      axi_write(8'h0C, 32'hFFFFFFFF, 4'hF, PCM_RESP_SLVERR);
      axi_read(8'h0C, {32'h0, PCM_RESP_SLVERR});
      axi_write(PCM_OFF_KEY, unlock_key, 4'hF, PCM_RESP_OKAY);
      check(pads_unlocked, 1'b1);
      // one key opens every pad word; reserved bits come back low
      for (int i = 0; i < 3; i++) begin
         wd = $urandom();
         axi_write(8'(i * 4), wd, 4'hF, PCM_RESP_OKAY);
         axi_read(8'(i * 4), {wd & (i == 0 ? PCM_MASK_PADS_0_3 : i == 1 ? PCM_MASK_PADS_4_7
                                    : PCM_MASK_PADS_8_11), PCM_RESP_OKAY});
      end
      axi_write(8'h00, 32'hB7000000, 4'hF, PCM_RESP_OKAY);
      check(pad_cfg[3], {3'h6, 1'b1, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0});
      axi_write(8'h04, 32'h00C08080, 4'hF, PCM_RESP_OKAY);
      check(pad_cfg[4].upper_pwr, 1'b1);
      check({pad_cfg[6].pullup_res, pad_cfg[5].pullup_res}, 4'hE);
      axi_write(8'h08, 32'h40000000, 4'hF, PCM_RESP_OKAY);
      check(pad_cfg[11].lower_pwr, 1'b1);
      for (int p = 0; p < 8; p++) begin
         for (int c = 0; c < 8; c++) pad_route(p, 3'(c));
      end
      // pins held high while input enable is cleared must not reach any function
      pad_in <= 12'hFFF;
      axi_write(8'h00, PCM_RST_PADS, 4'hF, PCM_RESP_OKAY);
      repeat (5) @(posedge clk);
      check(periph_in[1], 8'h00);
      check(periph_in[0], 8'h00);
      // any other key value locks again
      axi_write(PCM_OFF_KEY, 32'h0, 4'hF, PCM_RESP_OKAY);
      check(pads_unlocked, 1'b0);
      axi_write(8'h04, 32'hFFFFFFFF, 4'hF, PCM_RESP_SLVERR);
      axi_read(8'h04, {32'h3A3A3A3A, PCM_RESP_OKAY});
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule
`default_nettype wire
